// *** rtl/gpch_cfg.svh ***
// Constants of the global parameter command handler.
// Assumes inclusion by bare name; no processes here.
`ifndef GPCH_CFG_SVH
`define GPCH_CFG_SVH
`define GPCH_OP_RESTORE_AXIS 8'h08
`define GPCH_OP_SET 8'h09
`define GPCH_OP_GET 8'h0A
`define GPCH_OP_STORE 8'h0B
`define GPCH_OP_RESTORE 8'h0C
`define GPCH_BANK_GLOBAL 8'h00
`define GPCH_BANK_USER 8'h02
`define GPCH_BANK_IRQ 8'h03
`define GPCH_ST_OK 8'h64
`define GPCH_ST_BAD_CSUM 8'h01
`define GPCH_ST_BAD_CMD 8'h02
`define GPCH_ST_BAD_TYPE 8'h03
`define GPCH_ST_BAD_VALUE 8'h04
`define GPCH_FRAME_BYTES 4'h9
`define GPCH_BOOT_WORDS 9'h100
`define GPCH_RESET_VALUE 32'h0000_0000
`endif

// *** rtl/gpch_pkg.sv ***
// Types of the global parameter command handler.
// Assumes gpch_cfg.svh for numeric constants.
package gpch_pkg;
    typedef enum logic [2:0] {
        GPCH_BOOT,
        GPCH_RECV,
        GPCH_EXEC,
        GPCH_READ,
        GPCH_REPLY
    } gpch_state_t;
    typedef enum logic [1:0] {
        GPCH_AREA_GLOBAL,
        GPCH_AREA_USER,
        GPCH_AREA_IRQ,
        GPCH_AREA_AXIS
    } gpch_area_t;
endpackage

// *** rtl/gpch_mem.sv ***
// Small parameter memory with a registered read port.
// Assumes one clock, synchronous active-low reset on the read data only.
`timescale 1ns/1ps
module gpch_mem #(
    parameter int AW = 8,
    parameter int DW = 32
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic we_in,
    input wire logic [AW-1:0] waddr_in,
    input wire logic [DW-1:0] wdata_in,
    input wire logic [AW-1:0] raddr_in,
    output logic [DW-1:0] rdata_out
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
        if (!rst_n_in) begin
            rdata_out <= '0;
        end else begin
            rdata_out <= mem[raddr_in];
        end
    end
endmodule

// *** rtl/gpch_top.sv ***
// Global parameter command handler: frames in, replies out.
// Assumes one byte per strobe and a host that waits for each reply.
// Contract
// - Opcode 9 with bank 0, 2 or 3 writes value into selected parameter.
// - Bank 0 is module settings, 2 user variables, 3 interrupt setup.
// - Writing a bank 0 setting also commits it to non-volatile store.
// - Opcode 10 reads selected parameter into accumulator; value ignored.
// - Get reply carries status 100 and the value read.
// - Opcode 11 on bank 2 copies user variable to non-volatile store.
// - Opcode 12 on bank 2 reloads user variable from non-volatile store.
// - After power-up all user variables load from stored copy first.
// - Opcode 8 reloads the named axis parameter from non-volatile store.
`include "gpch_cfg.svh"
`timescale 1ns/1ps
module gpch_top (
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic BYTE_VALID_IN,
    input wire logic [7:0] BYTE_IN,
    output logic BUSY_OUT,
    output logic REPLY_VALID_OUT,
    output logic [7:0] REPLY_STATUS_OUT,
    output logic [7:0] REPLY_OPCODE_OUT,
    output logic [31:0] REPLY_VALUE_OUT,
    output logic [31:0] ACCU_OUT,
    output logic [31:0] AXIS_PARAM_OUT,
    output logic [7:0] AXIS_INDEX_OUT,
    output logic AXIS_LOAD_OUT
);
    // Volatile store, 4 areas of 256; shadow is the non-volatile copy
    logic [7:0] frame [0:8];
    logic [3:0] cnt, next_cnt;
    logic [7:0] csum, next_csum;
    logic [8:0] boot_idx, next_boot_idx;
    gpch_pkg::gpch_state_t state, next_state;
    logic v_we, s_we, next_busy, next_rv, next_load;
    logic [9:0] v_waddr, v_raddr, s_waddr, s_raddr;
    logic [31:0] v_wdata, s_wdata, v_rdata, s_rdata;
    logic [7:0] next_status, next_opc, next_aidx;
    logic [31:0] next_rval, next_accu, next_apar;
    logic [1:0] area;
    logic bank_ok;
    logic [31:0] value;
    assign value = {frame[4], frame[5], frame[6], frame[7]};

    gpch_mem #(.AW(10), .DW(32)) u_vol (
        .clk_in(REF_CLK_IN), .rst_n_in(RST_N_IN), .we_in(v_we),
        .waddr_in(v_waddr), .wdata_in(v_wdata), .raddr_in(v_raddr),
        .rdata_out(v_rdata)
    );
    gpch_mem #(.AW(10), .DW(32)) u_nvm (
        .clk_in(REF_CLK_IN), .rst_n_in(RST_N_IN), .we_in(s_we),
        .waddr_in(s_waddr), .wdata_in(s_wdata), .raddr_in(s_raddr),
        .rdata_out(s_rdata)
    );

    always_comb begin
        bank_ok = 1'b1;
        area = 2'(gpch_pkg::GPCH_AREA_GLOBAL);
        unique case (frame[3])
            `GPCH_BANK_GLOBAL: area = 2'(gpch_pkg::GPCH_AREA_GLOBAL);
            `GPCH_BANK_USER: area = 2'(gpch_pkg::GPCH_AREA_USER);
            `GPCH_BANK_IRQ: area = 2'(gpch_pkg::GPCH_AREA_IRQ);
            default: bank_ok = 1'b0;
        endcase
        if (frame[1] == `GPCH_OP_RESTORE_AXIS) begin
            area = 2'(gpch_pkg::GPCH_AREA_AXIS);
        end
    end

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_csum = csum;
        next_boot_idx = boot_idx;
        next_busy = BUSY_OUT;
        next_rv = 1'b0;
        next_load = 1'b0;
        next_status = REPLY_STATUS_OUT;
        next_opc = REPLY_OPCODE_OUT;
        next_rval = REPLY_VALUE_OUT;
        next_accu = ACCU_OUT;
        next_apar = AXIS_PARAM_OUT;
        next_aidx = AXIS_INDEX_OUT;
        v_we = 1'b0;
        s_we = 1'b0;
        v_waddr = {area, frame[2]};
        v_wdata = value;
        v_raddr = {area, frame[2]};
        s_waddr = {area, frame[2]};
        s_wdata = v_rdata;
        s_raddr = {area, frame[2]};
        unique case (state)
            gpch_pkg::GPCH_BOOT: begin
                // Read leads write by one cycle, registered memory
                s_raddr = {2'(gpch_pkg::GPCH_AREA_USER), boot_idx[7:0]};
                if (boot_idx != 9'h000) begin
                    v_we = 1'b1;
                    v_waddr = {2'(gpch_pkg::GPCH_AREA_USER),
                               8'(boot_idx - 9'h001)};
                    v_wdata = s_rdata;
                end
                next_boot_idx = boot_idx + 9'h001;
                if (boot_idx == `GPCH_BOOT_WORDS) begin
                    next_state = gpch_pkg::GPCH_RECV;
                    next_busy = 1'b0;
                end
            end
            gpch_pkg::GPCH_RECV: begin
                if (BYTE_VALID_IN) begin
                    next_cnt = cnt + 4'h1;
                    if (cnt == `GPCH_FRAME_BYTES - 4'h1) begin
                        next_state = gpch_pkg::GPCH_READ;
                        next_busy = 1'b1;
                    end else begin
                        // Checksum byte itself stays out of the sum
                        next_csum = csum + BYTE_IN;
                    end
                end
            end
            gpch_pkg::GPCH_READ: begin
                // Both stores present data of the addressed slot now
                next_state = gpch_pkg::GPCH_EXEC;
            end
            gpch_pkg::GPCH_EXEC: begin
                next_state = gpch_pkg::GPCH_REPLY;
                next_opc = frame[1];
                next_rval = `GPCH_RESET_VALUE;
                next_status = `GPCH_ST_OK;
                if (csum != frame[8]) begin
                    next_status = `GPCH_ST_BAD_CSUM;
                end else begin
                    unique case (frame[1])
                        `GPCH_OP_SET: begin
                            if (bank_ok) begin
                                v_we = 1'b1;
                                s_we = (area == 2'(
                                    gpch_pkg::GPCH_AREA_GLOBAL));
                                s_wdata = value;
                            end else begin
                                next_status = `GPCH_ST_BAD_VALUE;
                            end
                        end
                        `GPCH_OP_GET: begin
                            if (bank_ok) begin
                                next_accu = v_rdata;
                                next_rval = v_rdata;
                            end else begin
                                next_status = `GPCH_ST_BAD_VALUE;
                            end
                        end
                        `GPCH_OP_STORE: begin
                            if (frame[3] == `GPCH_BANK_USER) begin
                                s_we = 1'b1;
                            end else begin
                                next_status = `GPCH_ST_BAD_VALUE;
                            end
                        end
                        `GPCH_OP_RESTORE: begin
                            if (frame[3] == `GPCH_BANK_USER) begin
                                v_we = 1'b1;
                                v_wdata = s_rdata;
                            end else begin
                                next_status = `GPCH_ST_BAD_VALUE;
                            end
                        end
                        `GPCH_OP_RESTORE_AXIS: begin
                            v_we = 1'b1;
                            v_wdata = s_rdata;
                            next_apar = s_rdata;
                            next_aidx = frame[2];
                            next_load = 1'b1;
                        end
                        default: next_status = `GPCH_ST_BAD_CMD;
                    endcase
                end
            end
            gpch_pkg::GPCH_REPLY: begin
                next_rv = 1'b1;
                next_busy = 1'b0;
                next_cnt = 4'h0;
                next_csum = 8'h00;
                next_state = gpch_pkg::GPCH_RECV;
            end
            default: next_state = gpch_pkg::GPCH_RECV;
        endcase
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (state == gpch_pkg::GPCH_RECV && BYTE_VALID_IN) begin
            frame[cnt] <= BYTE_IN;
        end
        if (!RST_N_IN) begin
            state <= gpch_pkg::GPCH_BOOT;
            cnt <= 4'h0;
            csum <= 8'h00;
            boot_idx <= 9'h000;
            BUSY_OUT <= 1'b1;
            REPLY_VALID_OUT <= 1'b0;
            REPLY_STATUS_OUT <= 8'h00;
            REPLY_OPCODE_OUT <= 8'h00;
            REPLY_VALUE_OUT <= `GPCH_RESET_VALUE;
            ACCU_OUT <= `GPCH_RESET_VALUE;
            AXIS_PARAM_OUT <= `GPCH_RESET_VALUE;
            AXIS_INDEX_OUT <= 8'h00;
            AXIS_LOAD_OUT <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            csum <= next_csum;
            boot_idx <= next_boot_idx;
            BUSY_OUT <= next_busy;
            REPLY_VALID_OUT <= next_rv;
            REPLY_STATUS_OUT <= next_status;
            REPLY_OPCODE_OUT <= next_opc;
            REPLY_VALUE_OUT <= next_rval;
            ACCU_OUT <= next_accu;
            AXIS_PARAM_OUT <= next_apar;
            AXIS_INDEX_OUT <= next_aidx;
            AXIS_LOAD_OUT <= next_load;
        end
    end
endmodule

// *** verif/gpch_properties.sv ***
// Port checker for the command handler.
// Assumes whole nine-byte frames only.
`timescale 1ns/1ps
module gpch_checker (
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic BYTE_VALID_IN,
    input wire logic [7:0] BYTE_IN,
    input wire logic BUSY_OUT,
    input wire logic REPLY_VALID_OUT,
    input wire logic [7:0] REPLY_STATUS_OUT,
    input wire logic [7:0] REPLY_OPCODE_OUT,
    input wire logic [31:0] REPLY_VALUE_OUT,
    input wire logic [31:0] ACCU_OUT,
    input wire logic [31:0] AXIS_PARAM_OUT,
    input wire logic [7:0] AXIS_INDEX_OUT,
    input wire logic AXIS_LOAD_OUT
);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    logic [3:0] cnt;
    logic [7:0] sum, op, bank;
    logic last, good, okb;
    assign last = BYTE_VALID_IN && !BUSY_OUT && cnt == 4'h8;
    assign good = last && sum == BYTE_IN;
    assign okb = bank == 8'h00 || bank == 8'h02 || bank == 8'h03;
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN || last) begin
            cnt <= 4'h0;
            sum <= 8'h00;
        end else if (BYTE_VALID_IN && !BUSY_OUT) begin
            cnt <= cnt + 4'h1;
            sum <= sum + BYTE_IN;
            if (cnt == 4'h1) op <= BYTE_IN;
            if (cnt == 4'h3) bank <= BYTE_IN;
        end
    end
    sequence s_exec;
        BUSY_OUT [*3] ##1 (!BUSY_OUT && REPLY_VALID_OUT);
    endsequence
    chk_reply_after_frame: assert property (last |=> s_exec)
        else $error("reply timing wrong");
    chk_bad_checksum: assert property (
        last && sum != BYTE_IN |-> ##4 REPLY_STATUS_OUT == 8'h01)
        else $error("bad checksum not refused");
    chk_set_ok: assert property (
        good && op == 8'h09 && okb |-> ##4 REPLY_STATUS_OUT == 8'h64)
        else $error("set not answered ok");
    chk_get_reply: assert property (
        good && op == 8'h0A && okb |-> ##4
        (REPLY_STATUS_OUT == 8'h64 && ACCU_OUT == REPLY_VALUE_OUT))
        else $error("get reply wrong");
    chk_store_bank: assert property (
        good && (op == 8'h0B || op == 8'h0C) && bank != 8'h02 |-> ##4
        REPLY_STATUS_OUT == 8'h04)
        else $error("store bank not refused");
    chk_axis_load: assert property (AXIS_LOAD_OUT |=>
        REPLY_VALID_OUT && REPLY_OPCODE_OUT == 8'h08)
        else $error("axis load without reply");
    // Reset clears the accumulator too; that edge is no get
    chk_accu_only_get: assert property (
        $changed(ACCU_OUT) && $past(RST_N_IN) |->
        ##[0:1] (REPLY_VALID_OUT && REPLY_OPCODE_OUT == 8'h0A))
        else $error("accumulator changed outside get");
    chk_boot_len: assert property ($rose(RST_N_IN) |->
        ##256 BUSY_OUT ##1 !BUSY_OUT)
        else $error("boot copy length wrong");
endmodule
bind gpch_top gpch_checker chk_u (.*);

// *** verif/gpch_host.sv ***
// Host model: sends nine-byte command frames.
// Assumes the handler's byte strobe and busy flag.
`timescale 1ns/1ps
module gpch_host (
    input wire logic clk_in,
    input wire logic busy_in,
    output logic valid_out = 1'b0,
    output logic [7:0] byte_out = 8'h00
);
    task automatic send(input logic [7:0] op, typ, bank,
                        input logic [31:0] v, input logic bad);
        logic [7:0] b[9];
        b = '{8'h01, op, typ, bank, v[31:24], v[23:16], v[15:8], v[7:0],
              8'h00};
        for (int i = 0; i < 8; i++) b[8] += b[i];
        if (bad) b[8] = ~b[8];
        while (busy_in) @(posedge clk_in);
        for (int i = 0; i < 9; i++) begin
            @(posedge clk_in);
            valid_out <= 1'b1;
            byte_out <= b[i];
        end
        @(posedge clk_in);
        valid_out <= 1'b0;
        byte_out <= ~b[8]; // Released line must not look stale
    endtask
endmodule

// *** verif/gpch_top_tb_top.sv ***
// Testbench for the command handler.
// Assumes the host model and checker compile first.
`timescale 1ns/1ps
module gpch_top_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic valid, busy, rv, ld;
    logic [7:0] data, st, opc, idx;
    logic [31:0] val, accu, axv;
    int errors = 0;
    int comparisons = 0;
    always #2 clk = ~clk;
    gpch_host host_u (.clk_in(clk), .busy_in(busy), .valid_out(valid),
        .byte_out(data));
    gpch_top dut_u (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .BYTE_VALID_IN(valid),
        .BYTE_IN(data), .BUSY_OUT(busy), .REPLY_VALID_OUT(rv),
        .REPLY_STATUS_OUT(st), .REPLY_OPCODE_OUT(opc), .REPLY_VALUE_OUT(val),
        .ACCU_OUT(accu), .AXIS_PARAM_OUT(axv), .AXIS_INDEX_OUT(idx),
        .AXIS_LOAD_OUT(ld));
    task automatic check(input string what, input logic [31:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic boot(input int hold);
        int n = 0;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (hold) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        while (busy !== 1'b0 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("boot busy", 1'b0, busy);
    endtask
    task automatic run(input logic [7:0] op, typ, bank, input logic [31:0] v,
                       input logic bad, input logic [7:0] exp_st);
        int n = 0;
        logic saw_ld = 1'h0;
        host_u.send(op, typ, bank, v, bad);
        while (rv !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            saw_ld = saw_ld | ld;
            n++;
        end
        // A missing reply counts, stale status must not pass
        check("reply valid", 1'h1, rv);
        check("status", exp_st, st);
        check("opcode", op, opc);
        check("axis load", op == 8'h08 && !bad, saw_ld);
    endtask
    task automatic t_set_get;
        logic [7:0] banks[3] = '{8'h00, 8'h02, 8'h03};
        logic [31:0] pat;
        foreach (banks[i]) begin
            pat = {24'hA5_C3E1, banks[i]};
            run(8'h09, 8'h21, banks[i], pat, 1'h0, 8'h64);
            run(8'h0A, 8'h21, banks[i], 32'hFFFF_FFFF, 1'h0, 8'h64);
            check("get value", pat, val);
            check("accu", pat, accu);
        end
        run(8'h0A, 8'h21, 8'h00, 32'h0000_0000, 1'h0, 8'h64);
        check("bank split", 32'hA5C3_E100, val);
    endtask
    task automatic t_store;
        run(8'h09, 8'h2A, 8'h02, 32'h1111_2222, 1'h0, 8'h64);
        run(8'h0B, 8'h2A, 8'h02, 32'hDEAD_0000, 1'h0, 8'h64);
        run(8'h09, 8'h2A, 8'h02, 32'h3333_4444, 1'h0, 8'h64);
        run(8'h0C, 8'h2A, 8'h02, 32'h0000_0000, 1'h0, 8'h64);
        run(8'h0A, 8'h2A, 8'h02, 32'h0000_0000, 1'h0, 8'h64);
        check("restored", 32'h1111_2222, val);
        run(8'h0B, 8'h2A, 8'h00, 32'h0000_0000, 1'h0, 8'h04);
        run(8'h0C, 8'h2A, 8'h03, 32'h0000_0000, 1'h0, 8'h04);
        // Live copy differs first, so only the boot load can restore it
        run(8'h09, 8'h2A, 8'h02, 32'h5555_6666, 1'h0, 8'h64);
        boot(1);
        run(8'h0A, 8'h2A, 8'h02, 32'h0000_0000, 1'h0, 8'h64);
        check("boot load", 32'h1111_2222, val);
    endtask
    task automatic t_errors;
        run(8'h09, 8'h2A, 8'h02, 32'h5555_5555, 1'h1, 8'h01);
        run(8'h0D, 8'h2A, 8'h02, 32'h0000_0000, 1'h0, 8'h02);
        run(8'h09, 8'h2A, 8'h01, 32'h7777_7777, 1'h0, 8'h04);
        run(8'h0A, 8'h2A, 8'h01, 32'h0000_0000, 1'h0, 8'h04);
        check("accu kept", 32'h1111_2222, accu);
        run(8'h0A, 8'h2A, 8'h02, 32'h0000_0000, 1'h0, 8'h64);
        check("not written", 32'h1111_2222, val);
        run(8'h08, 8'h06, 8'h00, 32'h0000_0000, 1'h0, 8'h64);
        check("axis index", 8'h06, idx);
    endtask
    initial begin
        boot(3);
        t_set_get();
        t_store();
        t_errors();
        finish_test();
    end
    initial begin
        #100000;
        errors++;
        finish_test();
    end
endmodule
